/* File: logic/prog_port_pkg.sv */
// Shared constants for the programmer parallel port, both ends.
// Assumes one 10 MHz clock per end; link pins are asynchronous.
package prog_port_pkg;
  // Clock and timing
  localparam int CLK_MHZ       = 10;
  localparam int INIT_HOLD_US  = 500;
  localparam int INIT_HOLD_CYC = INIT_HOLD_US * CLK_MHZ;
  localparam int STROBE_CYC    = 3;
  localparam logic [12:0] CNT_ONE = 13'h0001;
  // Synchronised command vector positions (device side)
  localparam int CMD_WD   = 0;
  localparam int CMD_CH   = 1;
  localparam int CMD_LO   = 2;
  localparam int CMD_RD   = 3;
  localparam int CMD_RS   = 4;
  localparam int CMD_INIT = 5;
  // Control/high-address byte layout
  localparam int HI_MSB   = 3;
  localparam int MODE_LSB = 4;
  localparam int MODE_NIB = 0;
  localparam int MODE_SOC = 1;
  localparam int MODE_STR = 2;
  localparam int CTL1_BIT = 7;
  // Status word bit positions
  localparam int ST_BUSY  = 0;
  localparam int ST_FLAG0 = 1;
  localparam logic [7:0] ST_RESET = 8'h00;
  // Host register map (APB byte offsets)
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_RESULT = 8'h04;
  localparam int CMD_OP_LSB  = 8;
  localparam int RES_BUSY    = 8;
  localparam int RES_VALID   = 9;
  // Host operation codes
  localparam logic [2:0] OP_WD   = 3'h1;
  localparam logic [2:0] OP_CH   = 3'h2;
  localparam logic [2:0] OP_LO   = 3'h3;
  localparam logic [2:0] OP_RD   = 3'h4;
  localparam logic [2:0] OP_RS   = 3'h5;
  localparam logic [2:0] OP_INIT = 3'h6;
endpackage

/* File: logic/prog_link_if.sv */
// Link between control computer end and programmer end.
// All lines are active low and each runs in one direction only.
`timescale 1ns/100ps
`default_nettype none
interface prog_link_if;
  logic [7:0] write_bus_n;
  logic       write_data_strobe_n;
  logic       control_high_strobe_n;
  logic       low_address_strobe_n;
  logic       read_data_cmd_n;
  logic       read_status_cmd_n;
  logic       init_n;
  logic [7:0] read_bus_n;
  logic       read_ack_n;
  modport dev (
    input  write_bus_n, write_data_strobe_n, control_high_strobe_n,
    input  low_address_strobe_n, read_data_cmd_n, read_status_cmd_n,
    input  init_n,
    output read_bus_n, read_ack_n
  );
  modport host (
    output write_bus_n, write_data_strobe_n, control_high_strobe_n,
    output low_address_strobe_n, read_data_cmd_n, read_status_cmd_n,
    output init_n,
    input  read_bus_n, read_ack_n
  );
endinterface
`default_nettype wire

/* File: logic/prog_port_dev.sv */
// Programmer end of the parallel port: latches, controller, read bus.
// Assumes link pins asynchronous; memory side on I_CLK.
// Functional notes
// - All link lines are asserted low
// - Two one-way 8-bit buses plus control lines
// - Data read command reads addressed memory location
// - Status command acknowledges directly, no controller
// - Read bus shows status unless data command
// - Active command selects bus content, bit0 LSB
// - Status bits: busy, done, fails, errors, card
// - Write strobe latches byte, starts programming
// - Nibble select picks half for 4-bit memories
// - Nibble bit 4: one low half
// - Control strobe: mode bits, top address bits
// - Socket bit 5: one selects first socket
// - Start-read bit 6 starts read on strobe
// - Host writes reserved control bit as zero
// - Low strobe stores low eight address bits
// - Host drives byte matching its strobe
// - Acknowledge marks read bus content valid
// - Init aborts work, controller idles, 500 us
`timescale 1ns/100ps
`default_nettype none
module prog_port_dev
  import prog_port_pkg::*;
(
  // Clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_ARST_N,
  // Link to control computer
  prog_link_if.dev         link,
  // Memory access side
  output logic [11:0]      O_MEM_ADDR,
  output logic             O_MEM_SOCKET,
  output logic             O_MEM_RD,
  output logic             O_MEM_WR,
  output logic [7:0]       O_MEM_WDATA,
  input  wire logic        I_MEM_DONE,
  input  wire logic [7:0]  I_MEM_RDATA,
  input  wire logic        I_NIBBLE_WIDE,
  // Outcome flags, sampled with I_MEM_DONE
  input  wire logic        I_PROG_FAIL,
  input  wire logic        I_PROG_REFUSED,
  input  wire logic        I_ADDR_ERR,
  input  wire logic        I_HW_FAULT,
  input  wire logic        I_NO_CARD,
  // Controller state
  output logic             O_BUSY
);

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10
  } dev_state_e;

  typedef struct packed {
    logic [7:0] wb_m;
    logic [7:0] wb;
    logic [5:0] cmd_m;
    logic [5:0] cmd;
    logic [5:0] cmd_d;
    logic [7:0] wr_data;
    logic [3:0] mode;
    logic [3:0] hi_addr;
    logic [7:0] lo_addr;
    dev_state_e st;
    logic [7:0] rd_byte;
    logic       rd_valid;
    logic [5:0] flags;
    logic       mem_rd;
    logic       mem_wr;
    logic [7:0] mem_wdata;
    logic [7:0] bus_n;
    logic       ack_n;
  } dev_s;

  // Idle link lines are high, so the answer pins reset high
  localparam dev_s DEV_RESET = '{
    wb_m: 8'h00, wb: 8'h00, cmd_m: 6'h00, cmd: 6'h00, cmd_d: 6'h00,
    wr_data: 8'h00, mode: 4'h0, hi_addr: 4'h0, lo_addr: 8'h00,
    st: ST_IDLE, rd_byte: 8'h00, rd_valid: 1'b0, flags: 6'h00,
    mem_rd: 1'b0, mem_wr: 1'b0, mem_wdata: 8'h00,
    bus_n: 8'hFF, ack_n: 1'b1
  };

  dev_s s;
  dev_s next_s;

  logic [5:0] rise;
  logic [7:0] status;
  logic       busy;

  // Status word assembly; flags are meaningful only while not busy
  assign busy = (s.st != ST_IDLE);
  always_comb
  begin
    status          = ST_RESET;
    status[ST_BUSY] = busy;
    status[ST_FLAG0 +: 6] = s.flags;
  end

  // Edges of the synchronised commands; a held line acts once
  assign rise = s.cmd & ~s.cmd_d;

  // Controller next state
  always_comb
  begin
    next_s        = s;
    next_s.mem_rd = 1'b0;
    next_s.mem_wr = 1'b0;
    // Pins pass two flops; inversion makes everything active high
    next_s.wb_m  = ~link.write_bus_n;
    next_s.wb    = s.wb_m;
    next_s.cmd_m = ~{link.init_n, link.read_status_cmd_n,
                     link.read_data_cmd_n, link.low_address_strobe_n,
                     link.control_high_strobe_n,
                     link.write_data_strobe_n};
    next_s.cmd   = s.cmd_m;
    next_s.cmd_d = s.cmd;

    // Address and mode latches; a new address drops a prefetch
    if (rise[CMD_CH])
    begin
      next_s.mode     = s.wb[7:MODE_LSB];
      next_s.hi_addr  = s.wb[HI_MSB:0];
      next_s.rd_valid = 1'b0;
    end
    if (rise[CMD_LO])
    begin
      next_s.lo_addr  = s.wb;
      next_s.rd_valid = 1'b0;
    end
    if (rise[CMD_WD])
      next_s.wr_data = s.wb;
    // A fetched byte serves one data command only
    if (s.cmd_d[CMD_RD] && !s.cmd[CMD_RD])
      next_s.rd_valid = 1'b0;

    case (s.st)
      ST_IDLE:
      begin
        if (rise[CMD_WD])
        begin
          next_s.st     = ST_WRITE;
          next_s.mem_wr = 1'b1;
          next_s.flags  = 6'h00;
          // Narrow parts take one half of the byte
          if (!I_NIBBLE_WIDE)
            next_s.mem_wdata = s.wb;
          else if (s.mode[MODE_NIB])
            next_s.mem_wdata = {4'h0, s.wb[3:0]};
          else
            next_s.mem_wdata = {4'h0, s.wb[7:4]};
        end
        else if ((rise[CMD_RD] && !s.rd_valid) ||
                 (rise[CMD_CH] && s.wb[MODE_LSB + MODE_STR]))
        begin
          next_s.st       = ST_READ;
          next_s.mem_rd   = 1'b1;
          next_s.rd_valid = 1'b0;
          next_s.flags    = 6'h00;
        end
      end
      ST_READ, ST_WRITE:
      begin
        if (I_MEM_DONE)
        begin
          next_s.st    = ST_IDLE;
          next_s.flags = {I_NO_CARD, I_HW_FAULT, I_ADDR_ERR,
                          I_PROG_REFUSED, I_PROG_FAIL,
                          ~(I_NO_CARD | I_HW_FAULT | I_ADDR_ERR |
                            I_PROG_REFUSED | I_PROG_FAIL)};
          if (s.st == ST_READ)
          begin
            next_s.rd_byte  = I_MEM_RDATA;
            next_s.rd_valid = 1'b1;
          end
        end
      end
      default:
        next_s.st = ST_IDLE;
    endcase

    // Init overrides state, memory requests, prefetch and flags, leaving the controller idle
    if (s.cmd[CMD_INIT])
    begin
      next_s.st       = ST_IDLE;
      next_s.mem_rd   = 1'b0;
      next_s.mem_wr   = 1'b0;
      next_s.rd_valid = 1'b0;
      next_s.flags    = 6'h00;
    end

    // Read bus: memory byte only while the data command is held
    if (s.cmd[CMD_RD])
      next_s.bus_n = ~s.rd_byte;
    else
      next_s.bus_n = ~status;
    // Status acknowledge bypasses the controller entirely
    next_s.ack_n = ~(s.cmd[CMD_RS] ||
                     (s.cmd[CMD_RD] && s.rd_valid));
  end

  // State register
  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      s <= DEV_RESET;
    else
      s <= next_s;
  end

  // Outputs straight from the state
  assign link.read_bus_n = s.bus_n;
  assign link.read_ack_n = s.ack_n;
  assign O_MEM_ADDR      = {s.hi_addr, s.lo_addr};
  assign O_MEM_SOCKET    = s.mode[MODE_SOC];
  assign O_MEM_RD        = s.mem_rd;
  assign O_MEM_WR        = s.mem_wr;
  assign O_MEM_WDATA     = s.mem_wdata;
  assign O_BUSY          = busy;

endmodule
`default_nettype wire

/* File: logic/prog_port_host.sv */
// Control computer end: APB slave registers drive the link sequences.
// Assumes the programmer end samples pins through two flops.
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module prog_port_host
  import prog_port_pkg::*;
#(
  parameter int INIT_HOLD = INIT_HOLD_CYC
)
(
  // Clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_ARST_N,
  // APB slave
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic [31:0]      O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  // Link to programmer
  prog_link_if.host        link
);

  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_SETUP = 3'b001,
    H_PULSE = 3'b010,
    H_HOLD  = 3'b011,
    H_RWAIT = 3'b100,
    H_RREL  = 3'b101,
    H_INIT  = 3'b110
  } host_state_e;

  typedef struct packed {
    host_state_e st;
    logic [12:0] cnt;
    logic [2:0]  op;
    logic [7:0]  wb_n;
    logic [2:0]  stb_n;
    logic [1:0]  rcmd_n;
    logic        init_n;
    logic        ack_m;
    logic        ack;
    logic [7:0]  bus_m;
    logic [7:0]  bus;
    logic [7:0]  result;
    logic        res_valid;
    logic [31:0] rdata;
  } host_s;

  localparam host_s HOST_RESET = '{
    st: H_IDLE, cnt: 13'h0000, op: 3'h0, wb_n: 8'hFF, stb_n: 3'h7,
    rcmd_n: 2'h3, init_n: 1'b1, ack_m: 1'b0, ack: 1'b0,
    bus_m: 8'h00, bus: 8'h00, result: 8'h00, res_valid: 1'b0,
    rdata: 32'h0000_0000
  };
  localparam logic [12:0] STB_CNT  = 13'(STROBE_CYC);
  // One extra count: the pin only falls at the load edge itself
  localparam logic [12:0] INIT_CNT = 13'(INIT_HOLD) + CNT_ONE;

  host_s s;
  host_s next_s;

  logic       busy;
  logic       acc;
  logic       hit_cmd;
  logic       hit_res;
  logic [2:0] wop;
  logic [31:0] rd_word;

  // APB decode; zero wait states, writes act in the access cycle
  assign busy     = (s.st != H_IDLE);
  assign acc      = I_PSEL && I_PENABLE;
  assign hit_cmd  = (I_PADDR == REG_CMD);
  assign hit_res  = (I_PADDR == REG_RESULT);
  assign wop      = I_PWDATA[CMD_OP_LSB +: 3];
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = acc && ((!hit_cmd && !hit_res) ||
                             (hit_cmd && I_PWRITE && busy) ||
                             (hit_res && I_PWRITE));

  // Read word over registered state, registered again below
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (hit_cmd)
      rd_word[CMD_OP_LSB +: 3] = s.op;
    else if (hit_res)
    begin
      rd_word[7:0]       = s.result;
      rd_word[RES_BUSY]  = busy;
      rd_word[RES_VALID] = s.res_valid;
    end
  end

  // Sequencer next state
  always_comb
  begin
    next_s       = s;
    // Answer pins from the far end pass two flops
    next_s.ack_m = ~link.read_ack_n;
    next_s.ack   = s.ack_m;
    next_s.bus_m = ~link.read_bus_n;
    next_s.bus   = s.bus_m;
    // Word taken in the setup cycle, so prdata stands from a flop
    if (I_PSEL && !I_PENABLE)
      next_s.rdata = rd_word;
    if (s.cnt != 13'h0000)
      next_s.cnt = s.cnt - CNT_ONE;

    case (s.st)
      H_IDLE:
      begin
        if (acc && I_PWRITE && hit_cmd)
        begin
          next_s.op = wop;
          case (wop)
            OP_WD, OP_LO:
            begin
              next_s.wb_n = ~I_PWDATA[7:0];
              next_s.st   = H_SETUP;
              next_s.cnt  = STB_CNT;
            end
            OP_CH:
            begin
              next_s.wb_n = ~{1'b0, I_PWDATA[6:0]};
              next_s.st   = H_SETUP;
              next_s.cnt  = STB_CNT;
            end
            OP_RD:
            begin
              next_s.rcmd_n[0] = 1'b0;
              next_s.res_valid = 1'b0;
              next_s.st        = H_RWAIT;
            end
            OP_RS:
            begin
              next_s.rcmd_n[1] = 1'b0;
              next_s.res_valid = 1'b0;
              next_s.st        = H_RWAIT;
            end
            OP_INIT:
            begin
              next_s.init_n = 1'b0;
              next_s.cnt    = INIT_CNT;
              next_s.st     = H_INIT;
            end
            default:
              next_s.st = H_IDLE;
          endcase
        end
      end
      // Data settles before the strobe and stays after it
      H_SETUP:
        if (s.cnt == CNT_ONE)
        begin
          next_s.st  = H_PULSE;
          next_s.cnt = STB_CNT;
          if (s.op == OP_WD)
            next_s.stb_n[0] = 1'b0;
          else if (s.op == OP_CH)
            next_s.stb_n[1] = 1'b0;
          else
            next_s.stb_n[2] = 1'b0;
        end
      H_PULSE:
        if (s.cnt == CNT_ONE)
        begin
          next_s.stb_n = 3'h7;
          next_s.st    = H_HOLD;
          next_s.cnt   = STB_CNT;
        end
      H_HOLD:
        if (s.cnt == CNT_ONE)
        begin
          next_s.wb_n = 8'hFF;
          next_s.st   = H_IDLE;
        end
      // Command held until acknowledge, bus sampled then
      H_RWAIT:
        if (s.ack)
        begin
          next_s.result    = s.bus;
          next_s.res_valid = 1'b1;
          next_s.rcmd_n    = 2'h3;
          next_s.st        = H_RREL;
        end
      // Next command waits for acknowledge to drop
      H_RREL:
        if (!s.ack)
          next_s.st = H_IDLE;
      H_INIT:
        if (s.cnt == CNT_ONE)
        begin
          next_s.init_n = 1'b1;
          next_s.st     = H_IDLE;
        end
      default:
        next_s.st = H_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      s <= HOST_RESET;
    else
      s <= next_s;
  end

  // Link pins from flops
  assign link.write_bus_n           = s.wb_n;
  assign link.write_data_strobe_n   = s.stb_n[0];
  assign link.control_high_strobe_n = s.stb_n[1];
  assign link.low_address_strobe_n  = s.stb_n[2];
  assign link.read_data_cmd_n       = s.rcmd_n[0];
  assign link.read_status_cmd_n     = s.rcmd_n[1];
  assign link.init_n                = s.init_n;
  assign O_PRDATA                   = s.rdata;

endmodule
`default_nettype wire

/* File: verification/prog_port_checker.sv */
// Checker for the link lines between the two port ends.
// Assumes the bench hands it the link signals and the host clock.
`timescale 1ns/100ps
`default_nettype none
module prog_port_checker
#(
  parameter int INIT_HOLD = 20
)
(
  // Clock and reset
  input wire logic       I_CLK,
  input wire logic       I_ARST_N,
  // Link lines, all active low
  input wire logic [7:0] write_bus_n,
  input wire logic       write_data_strobe_n,
  input wire logic       control_high_strobe_n,
  input wire logic       low_address_strobe_n,
  input wire logic       read_data_cmd_n,
  input wire logic       read_status_cmd_n,
  input wire logic       init_n,
  input wire logic [7:0] read_bus_n,
  input wire logic       read_ack_n
);
  logic [15:0] init_cnt;
  logic        strobe_on;
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_ARST_N);
  // Any write strobe asserted
  assign strobe_on = !(write_data_strobe_n && control_high_strobe_n
                       && low_address_strobe_n);
  // Init pulse length; a short pulse may leave work half aborted
  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      init_cnt <= 16'h0000;
    else if (init_n)
      init_cnt <= 16'h0000;
    else
      init_cnt <= init_cnt + 16'h0001;
  end
  a_status_ack_time: assert property (
    $fell(read_status_cmd_n) |-> ##[3:5] !read_ack_n)
    else $error("status acknowledge late");
  a_ack_cause: assert property (
    $fell(read_ack_n) |-> !read_status_cmd_n || !read_data_cmd_n)
    else $error("acknowledge without a read command");
  a_ack_holds: assert property (
    !read_ack_n && (!read_status_cmd_n || !read_data_cmd_n)
    |=> !read_ack_n) else $error("acknowledge dropped early");
  a_ack_release: assert property (
    (read_status_cmd_n && read_data_cmd_n) [*5] |-> read_ack_n)
    else $error("acknowledge stuck after release");
  a_status_bit7: assert property (
    (read_data_cmd_n) [*5] |-> read_bus_n[7])
    else $error("unused status bit asserted");
  a_ctl_bit7: assert property (
    !control_high_strobe_n |-> write_bus_n[7])
    else $error("reserved control bit asserted");
  a_bus_steady: assert property (
    strobe_on |-> $stable(write_bus_n))
    else $error("write bus moved under strobe");
  a_one_strobe: assert property (
    $onehot0(~{write_data_strobe_n, control_high_strobe_n,
               low_address_strobe_n})) else $error("two strobes");
  a_cmd_held: assert property (
    !read_status_cmd_n && read_ack_n |=> !read_status_cmd_n)
    else $error("status command dropped before ack");
  a_strobe_width: assert property (
    $fell(control_high_strobe_n) |=> !control_high_strobe_n [*2]
    ##1 control_high_strobe_n) else $error("strobe width wrong");
  a_init_hold: assert property (
    $rose(init_n) |-> init_cnt >= INIT_HOLD)
    else $error("init pulse too short");
  // Main scenarios reached
  c_status: cover property ($fell(read_status_cmd_n) ##[1:8] !read_ack_n);
  c_data: cover property (!read_data_cmd_n && !read_ack_n);
  c_init: cover property ($rose(init_n));
  c_ctl: cover property ($fell(control_high_strobe_n));
endmodule
`default_nettype wire

/* File: verification/programmer_host_parallel_port_tb_top.sv */
// Bench joining host end and programmer end through the link.
// Assumes APB-driven host; memory side answered by a simple stand-in.
`timescale 1ns/100ps
`default_nettype none
`define CHECK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("unexpected at %0t: got %0h, expected %0h", \
               $time, (got), (exp)); \
    end \
  end
module programmer_host_parallel_port_tb_top
  import prog_port_pkg::*;
;
  localparam int HOLD  = 20;
  localparam int LIMIT = 20000;
  typedef struct packed {
    logic       nib;
    logic [7:0] ctl, lo, wd, rdv;
    logic [4:0] err;
  } row_s;
  row_s rows [6] = '{'{1'b0, 8'h2A, 8'h5C, 8'hC3, 8'h96, 5'h00},
                     '{1'b1, 8'h1F, 8'hFF, 8'h3C, 8'h01, 5'h01},
                     '{1'b1, 8'h00, 8'h00, 8'hA7, 8'hFF, 5'h02},
                     '{1'b0, 8'h85, 8'h80, 8'h5A, 8'hFE, 5'h04},
                     '{1'b0, 8'h23, 8'h01, 8'hFF, 8'h00, 5'h08},
                     '{1'b1, 8'h3E, 8'h7F, 8'h81, 8'h7F, 5'h10}};
  logic        clk;
  logic        arst_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, mem_socket, mem_rd, mem_wr, busy;
  logic [11:0] mem_addr, wr_addr;
  logic [7:0]  mem_wdata, wr_data, ack_bus, ch_bus;
  logic        wr_sock;
  logic        mem_done = 1'b0, nib_wide = 1'b0;
  logic [7:0]  mem_rdata = 8'h00, mem_wait = 8'h00, mem_lat = 8'h05;
  logic [4:0]  flags = 5'h00;
  int          failures = 0, checks_done = 0, cycles = 0, rd_pulses = 0;
  prog_link_if link_if ();
  prog_port_host #(.INIT_HOLD(HOLD)) u_prog_port_host (
    .I_CLK(clk), .I_ARST_N(arst_n), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .link(link_if.host));
  prog_port_dev u_prog_port_dev (
    .I_CLK(clk), .I_ARST_N(arst_n), .link(link_if.dev),
    .O_MEM_ADDR(mem_addr), .O_MEM_SOCKET(mem_socket), .O_MEM_RD(mem_rd),
    .O_MEM_WR(mem_wr), .O_MEM_WDATA(mem_wdata), .I_MEM_DONE(mem_done),
    .I_MEM_RDATA(mem_rdata), .I_NIBBLE_WIDE(nib_wide),
    .I_PROG_FAIL(flags[0]), .I_PROG_REFUSED(flags[1]),
    .I_ADDR_ERR(flags[2]), .I_HW_FAULT(flags[3]), .I_NO_CARD(flags[4]),
    .O_BUSY(busy));
  prog_port_checker #(.INIT_HOLD(HOLD)) u_checker (
    .I_CLK(clk), .I_ARST_N(arst_n),
    .write_bus_n(link_if.write_bus_n),
    .write_data_strobe_n(link_if.write_data_strobe_n),
    .control_high_strobe_n(link_if.control_high_strobe_n),
    .low_address_strobe_n(link_if.low_address_strobe_n),
    .read_data_cmd_n(link_if.read_data_cmd_n),
    .read_status_cmd_n(link_if.read_status_cmd_n),
    .init_n(link_if.init_n), .read_bus_n(link_if.read_bus_n),
    .read_ack_n(link_if.read_ack_n));
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Memory stand-in and line watchers; latency set per test
  always @(posedge clk)
  begin
    mem_done <= (mem_wait == 8'h01) && !(mem_rd | mem_wr);
    if (mem_rd | mem_wr)
      mem_wait <= mem_lat;
    else if (mem_wait != 8'h00)
      mem_wait <= mem_wait - 8'h01;
    if (mem_rd)
      rd_pulses <= rd_pulses + 1;
    if (mem_wr)
      {wr_addr, wr_data, wr_sock} <= {mem_addr, mem_wdata, mem_socket};
    if (!link_if.read_ack_n)
      ack_bus <= link_if.read_bus_n;
    if (!link_if.control_high_strobe_n)
      ch_bus <= link_if.write_bus_n;
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      failures++;
      report_and_stop();
    end
  end
  // One APB transfer; request held until pready is seen
  task automatic apb(input logic wr, input logic [7:0] addr,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Poll the host until its sequence is over
  task automatic host_wait(output logic [31:0] res);
    logic err;
    do apb(1'b0, REG_RESULT, 32'h0, res, err);
    while (res[RES_BUSY] !== 1'b0);
  endtask
  task automatic run_op(input logic [2:0] op, input logic [7:0] b,
                        output logic [31:0] res);
    logic err;
    apb(1'b1, REG_CMD, {21'h0, op, b}, res, err);
    `CHECK(err, 1'b0)
    host_wait(res);
  endtask
  // Status polling is the only way software learns the end of work
  task automatic wait_idle(output logic [31:0] res);
    do run_op(OP_RS, 8'h00, res);
    while (res[ST_BUSY] !== 1'b0);
  endtask
  task automatic report_and_stop();
    if (failures == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    row_s        r;
    logic [31:0] res;
    logic        err;
    logic [7:0]  w;
    int          base;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    `CHECK({link_if.read_ack_n, link_if.init_n, busy}, 3'h6)
    run_op(OP_RS, 8'h00, res);
    `CHECK(res[7:0], 8'h00)
    `CHECK(ack_bus, 8'hFF)
    // Ordinary cases: address, program, status, read back
    foreach (rows[i])
    begin
      r = rows[i];
      w = !r.nib ? r.wd : {4'h0, r.ctl[4] ? r.wd[3:0] : r.wd[7:4]};
      nib_wide <= r.nib;
      flags <= r.err;
      mem_rdata <= r.rdv;
      run_op(OP_CH, r.ctl, res);
      `CHECK(ch_bus, ~{1'b0, r.ctl[6:0]})
      run_op(OP_LO, r.lo, res);
      run_op(OP_WD, r.wd, res);
      wait_idle(res);
      `CHECK(res[7:0], {1'b0, r.err, ~|r.err, 1'b0})
      `CHECK(ack_bus, ~{1'b0, r.err, ~|r.err, 1'b0})
      `CHECK({wr_sock, wr_addr}, {r.ctl[5], r.ctl[3:0], r.lo})
      `CHECK(wr_data, w)
      flags <= 5'h00;
      run_op(OP_RD, 8'h00, res);
      `CHECK(res[7:0], r.rdv)
      `CHECK(ack_bus, ~r.rdv)
    end
    // Refusals: read-only, unmapped, order while busy; an illegal op is taken without error
    apb(1'b1, REG_RESULT, 32'h1, res, err);
    `CHECK(err, 1'b1)
    apb(1'b0, 8'h08, 32'h0, res, err);
    `CHECK({err, res}, {1'b1, 32'h0})
    apb(1'b1, REG_CMD, 32'h0000_0700, res, err);
    `CHECK(err, 1'b0)
    apb(1'b1, REG_CMD, {21'h0, OP_LO, 8'h11}, res, err);
    apb(1'b1, REG_CMD, {21'h0, OP_LO, 8'h22}, res, err);
    `CHECK(err, 1'b1)
    host_wait(res);
    run_op(OP_WD, 8'h5A, res);
    wait_idle(res);
    `CHECK(wr_addr[7:0], 8'h11)
    // Start-read bit: one access serves the later data command
    mem_lat <= 8'h40;
    mem_rdata <= 8'h3D;
    base = rd_pulses;
    run_op(OP_CH, 8'h41, res);
    @(posedge clk iff mem_done);
    mem_rdata <= 8'hC2;
    run_op(OP_RD, 8'h00, res);
    `CHECK(res[7:0], 8'h3D)
    `CHECK(rd_pulses, base + 1)
    // Init in mid-programming: long memory latency keeps it busy
    mem_lat <= 8'hC8;
    run_op(OP_WD, 8'h77, res);
    `CHECK(busy, 1'b1)
    run_op(OP_INIT, 8'h00, res);
    `CHECK(busy, 1'b0)
    run_op(OP_RS, 8'h00, res);
    `CHECK(res[7:0], 8'h00)
    // Reset in mid-programming: both ends come back with idle lines
    run_op(OP_WD, 8'h3C, res);
    `CHECK(busy, 1'b1)
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    `CHECK({link_if.write_bus_n, link_if.read_bus_n, busy}, 17'h1FFFE)
    run_op(OP_RS, 8'h00, res);
    `CHECK(res[7:0], 8'h00)
    report_and_stop();
  end
endmodule
`default_nettype wire
